// *** src/llem_pkg.sv ***
package llem_pkg;
  // ************************************************************
  // Register map (byte addresses, one word each)
  // ************************************************************
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_LOOP = 8'h00;
  localparam logic [7:0] REG_TEST = 8'h04;
  localparam logic [7:0] REG_BLKERR = 8'h08;
  localparam logic [7:0] REG_BER_LO = 8'h0c;
  localparam logic [7:0] REG_BER_HI = 8'h10;
  localparam logic [7:0] REG_LPSEL = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;

  // Loop configuration fields
  localparam int LOOP_W = 6;
  localparam int LOOP_B1 = 0;
  localparam int LOOP_B2 = 1;
  localparam int LOOP_ALL = 2;
  localparam int LOOP_DIR = 3;
  localparam int LOOP_LOOP_TRANSPARENCY_BIT = 4;
  localparam int LOOP_DLB = 5;
  localparam logic [5:0] LOOP_RST = 6'h00;

  // Bit error channel select, one bit per channel
  localparam int BSEL_W = 3;
  localparam logic [2:0] BSEL_RST = 3'h0;
  localparam logic [1:0] LPSEL_RST = 2'h0;

  // ************************************************************
  // Command codes, line states, channels, M symbols
  // ************************************************************
  localparam logic [3:0] CI_DR = 4'h0;
  localparam logic [3:0] CI_AR = 4'h8;
  localparam logic [3:0] CI_AR1 = 4'h9;
  localparam logic [3:0] CI_AR2 = 4'ha;
  localparam logic [3:0] CI_AR4 = 4'hb;

  localparam logic [3:0] ST_DEACT = 4'h0;
  localparam logic [3:0] ST_SYNC_NO_TE = 4'h7;
  localparam logic [3:0] ST_LINK_SYNC = 4'h8;
  localparam logic [3:0] ST_WAIT_1MS = 4'h9;
  localparam logic [3:0] ST_TRANSP = 4'ha;

  localparam logic [1:0] CH_B1 = 2'h0;
  localparam logic [1:0] CH_B2 = 2'h1;
  localparam logic [1:0] CH_D = 2'h2;

  localparam logic [1:0] M_ZERO = 2'h0;
  localparam logic [1:0] M_PLUS = 2'h1;

  // Alternating request lasts this many frames
  localparam logic [3:0] ALT_LAST = 4'h7;
  localparam int ALT_FRAMES = 8;

  typedef enum logic [1:0] {MM_ZERO, MM_PLUS, MM_ALT} llem_mmode_e;
endpackage

// *** src/llem_sat_cnt.sv ***
`timescale 1ns/10ps
// Saturating counter with hold-reset and clear-on-read
module llem_sat_cnt #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Control
  input wire logic hold_clr_i,
  input wire logic clr_i,
  input wire logic [1:0] inc_i,
  // Count
  output logic [W-1:0] cnt_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } llem_cnt_s;

  llem_cnt_s q;
  llem_cnt_s d;
  logic [W:0] sum;

  // Next count; an increment in the clearing cycle is kept
  always_comb begin
    d = q;
    sum = {1'b0, q.cnt} + {{(W-1){1'b0}}, inc_i};
    if (hold_clr_i) begin
      d.cnt = '0;
    end else if (clr_i) begin
      d.cnt = W'(inc_i);
    end else if (sum[W]) begin
      d.cnt = '1;
    end else begin
      d.cnt = sum[W-1:0];
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cnt_o = q.cnt;
endmodule

// *** src/llem_monitor.sv ***
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
// Functional notes
// - Analog and framer-deframer loops carry B1, B2 and D together, far-end data ignored
// - Analog loop request feeds own line output back, line still transmitted
// - Repeater loop request sends plus/zero alternating M symbols for 8 frames
// - Terminal loop request sends plus; activation/deactivation request send zero
// - Without loop requests every M symbol sent is zero
// - Loop register selects B1, B2, both or all, and loop direction
// - Transparency bit: forward looped data, or substitute all-ones idle
// - Framer-deframer loop is always transparent
// - Framer-deframer loop set while deactivated makes later activation fail
// - Count block error per violating frame and per received plus M symbol
// - Reading block error count by monitor or register clears it
// - Block error counter counts only in the four active states, else reset
// - Block error counter saturates at 255
// - 16-bit bit error counter selectable on B1, B2 and D
// - Reading low byte of bit error counter resets it to zero
// - Nonzero channel select starts bit error counting, zero stops it
// - Bit error counter increments per received one in selected channels
module llem_monitor #(
  parameter logic [1:0] LINE_ID = 2'h0,
  parameter int BLK_W = 8,
  parameter int BER_W = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [llem_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Command/indicate channel
  input wire logic ci_valid_i,
  input wire logic [3:0] ci_code_i,
  // Line status from receiver
  input wire logic [3:0] lt_state_i,
  input wire logic frame_i,
  input wire logic cv_i,
  input wire logic m_rx_plus_i,
  // Monitor read of block error count
  input wire logic mon_rds_req_i,
  output logic mon_rds_valid_o,
  output logic [7:0] mon_rds_data_o,
  // Bearer and signalling bit path
  input wire logic bit_valid_i,
  input wire logic [1:0] bit_chan_i,
  input wire logic sys_bit_i,
  input wire logic line_bit_i,
  output logic bit_valid_o,
  output logic sys_bit_o,
  output logic line_bit_o,
  // Maintenance outputs
  output logic analog_loop_o,
  output logic [1:0] m_sym_o,
  output logic act_inhibit_o
);
  import llem_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [LOOP_W-1:0] loop;
    logic [BSEL_W-1:0] bsel;
    logic [1:0] line_port_select;
    llem_mmode_e mmode;
    logic [3:0] alt_cnt;
    logic alt_ph;
    logic [1:0] m_sym;
    logic analog;
    logic act_inh;
    logic cv_seen;
    logic mon_v;
    logic [7:0] mon_data;
    logic bit_v;
    logic sys_bit;
    logic line_bit;
  } llem_state_s;

  llem_state_s q;
  llem_state_s d;
  logic bus_req;
  logic rd;
  logic wr;
  logic port_hit;
  logic blk_active;
  logic blk_clr;
  logic ber_clr;
  logic [1:0] blk_inc;
  logic [1:0] ber_inc;
  logic chan_hit;
  logic in_loop;
  logic [BLK_W-1:0] blk_cnt;
  logic [BER_W-1:0] ber_cnt;

  // ************************************************************
  // Error counters
  // ************************************************************
  // Block error counter, 8-bit saturating
  // saturate at maximum
  llem_sat_cnt #(.W(BLK_W)) u_blk_cnt (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .hold_clr_i(!blk_active),
    .clr_i(blk_clr),
    .inc_i(blk_inc),
    .cnt_o(blk_cnt)
  );

  // Bit error counter, 16-bit saturating
  // sixteen bit saturating
  llem_sat_cnt #(.W(BER_W)) u_ber_cnt (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .hold_clr_i(1'b0),
    .clr_i(ber_clr),
    .inc_i(ber_inc),
    .cnt_o(ber_cnt)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    d = q;
    bus_req = wb_cyc_i && wb_stb_i && !q.ack;
    rd = bus_req && !wb_we_i;
    wr = bus_req && wb_we_i && wb_sel_i[0];
    port_hit = (q.line_port_select == LINE_ID);
    blk_active = (lt_state_i == ST_SYNC_NO_TE) || (lt_state_i == ST_LINK_SYNC) ||
                 (lt_state_i == ST_WAIT_1MS) || (lt_state_i == ST_TRANSP);
    blk_clr = mon_rds_req_i || (rd && wb_adr_i == REG_BLKERR);
    ber_clr = rd && port_hit && wb_adr_i == REG_BER_LO;
    blk_inc = frame_i ? ({1'b0, q.cv_seen || cv_i} + {1'b0, m_rx_plus_i}) : 2'h0;
    d.cv_seen = frame_i ? 1'b0 : (q.cv_seen || cv_i);
    chan_hit = (bit_chan_i == CH_B1 && q.bsel[0]) || (bit_chan_i == CH_B2 && q.bsel[1]) ||
               (bit_chan_i == CH_D && q.bsel[2]);
    ber_inc = {1'b0, bit_valid_i && line_bit_i && chan_hit};

    // Bus answer one cycle after the request
    d.ack = bus_req;
    d.rdata = '0;
    if (rd) begin
      case (wb_adr_i)
        REG_LOOP: d.rdata = {26'h000_0000, q.loop};
        REG_TEST: d.rdata = {29'h0000_0000, q.bsel};
        REG_BLKERR: d.rdata = {24'h00_0000, blk_cnt};
        REG_BER_LO: d.rdata = port_hit ? {24'h00_0000, ber_cnt[7:0]} : 32'h0000_0000;
        REG_BER_HI: d.rdata = port_hit ? {24'h00_0000, ber_cnt[15:8]} : 32'h0000_0000;
        REG_LPSEL: d.rdata = {30'h0000_0000, q.line_port_select};
        REG_STAT: d.rdata = {27'h000_0000, (q.bsel != BSEL_RST), q.act_inh,
                             (q.mmode == MM_ALT), (q.mmode == MM_PLUS), q.analog};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        REG_LOOP: d.loop = wb_dat_i[LOOP_W-1:0];
        // start and stop by channel select
        REG_TEST: if (port_hit) d.bsel = wb_dat_i[BSEL_W-1:0];
        REG_LPSEL: d.line_port_select = wb_dat_i[1:0];
        default: d.line_port_select = q.line_port_select;
      endcase
    end

    // activation blocked after loop set while deactivated
    if (!d.loop[LOOP_DLB]) begin
      d.act_inh = 1'b0;
    end else if (!q.loop[LOOP_DLB] && lt_state_i == ST_DEACT) begin
      d.act_inh = 1'b1;
    end

    // M symbol per frame, zero unless requested
    if (frame_i) begin
      case (q.mmode)
        MM_PLUS: d.m_sym = M_PLUS;
        MM_ALT: begin
          d.m_sym = q.alt_ph ? M_ZERO : M_PLUS;
          d.alt_ph = !q.alt_ph;
          if (q.alt_cnt == ALT_LAST) begin
            d.mmode = MM_ZERO;
          end else begin
            d.alt_cnt = q.alt_cnt + 4'h1;
          end
        end
        default: d.m_sym = M_ZERO;
      endcase
    end

    // Commands from the controller
    if (ci_valid_i) begin
      case (ci_code_i)
        CI_AR1: d.analog = 1'b1;
        CI_AR4: begin
          d.mmode = MM_ALT;
          d.alt_cnt = 4'h0;
          d.alt_ph = 1'b0;
        end
        CI_AR2: d.mmode = MM_PLUS;
        CI_AR, CI_DR: begin
          d.mmode = MM_ZERO;
          d.analog = 1'b0;
        end
        default: d.analog = q.analog;
      endcase
    end

    // Monitor answer carries the count before clearing
    d.mon_v = mon_rds_req_i;
    if (mon_rds_req_i) d.mon_data = blk_cnt;

    // loop path selection, all channels in analog loop
    in_loop = q.loop[LOOP_ALL] || (q.loop[LOOP_B1] && bit_chan_i == CH_B1) ||
              (q.loop[LOOP_B2] && bit_chan_i == CH_B2);
    d.bit_v = bit_valid_i;
    if (q.loop[LOOP_DLB]) begin
      d.line_bit = sys_bit_i;
      d.sys_bit = sys_bit_i;
    end else if (q.analog) begin
      d.line_bit = sys_bit_i;
      d.sys_bit = sys_bit_i;
    end else if (in_loop && !q.loop[LOOP_DIR]) begin
      d.sys_bit = sys_bit_i;
      d.line_bit = q.loop[LOOP_LOOP_TRANSPARENCY_BIT] ? sys_bit_i : 1'b1;
    end else if (in_loop) begin
      d.line_bit = line_bit_i;
      d.sys_bit = q.loop[LOOP_LOOP_TRANSPARENCY_BIT] ? line_bit_i : 1'b1;
    end else begin
      d.sys_bit = line_bit_i;
      d.line_bit = sys_bit_i;
    end
  end

  // ************************************************************
  // State register and outputs
  // ************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.loop <= LOOP_RST;
      q.bsel <= BSEL_RST;
      q.line_port_select <= LPSEL_RST;
      q.mmode <= MM_ZERO;
      q.m_sym <= M_ZERO;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign mon_rds_valid_o = q.mon_v;
  assign mon_rds_data_o = q.mon_data;
  assign bit_valid_o = q.bit_v;
  assign sys_bit_o = q.sys_bit;
  assign line_bit_o = q.line_bit;
  assign analog_loop_o = q.analog;
  assign m_sym_o = q.m_sym;
  assign act_inhibit_o = q.act_inh;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_blk_read;
    rd && wb_adr_i == REG_BLKERR;
  endsequence

  sequence s_cleared_small;
    blk_cnt <= 8'h02;
  endsequence

  a_blk_read_clear: assert property (s_blk_read |=> s_cleared_small)
    else $error("Block error count not cleared by read");
  a_blk_saturate: assert property (blk_cnt == 8'hff && blk_active && !blk_clr
    |=> blk_cnt == 8'hff)
    else $error("Block error count left saturation");
  a_blk_hold_reset: assert property (!blk_active |=> blk_cnt == 8'h00)
    else $error("Block error count not held reset");
  a_blk_frame_count: assert property (blk_active && !blk_clr && frame_i && m_rx_plus_i &&
    blk_cnt < 8'hf0 |=> blk_cnt > $past(blk_cnt))
    else $error("Far-end block error not counted");
  a_ber_lo_clear: assert property (ber_clr |=> ber_cnt <= 16'h0001)
    else $error("Bit error count not reset by low read");
  a_ber_stopped: assert property (q.bsel == BSEL_RST && !ber_clr
    |=> ber_cnt == $past(ber_cnt))
    else $error("Bit error count moved while stopped");
  a_ber_one_count: assert property (bit_valid_i && line_bit_i && chan_hit && !ber_clr &&
    ber_cnt != 16'hffff |=> ber_cnt == $past(ber_cnt) + 16'h0001)
    else $error("Received one not counted");
  a_ber_saturate: assert property (ber_cnt == 16'hffff && !ber_clr
    |=> ber_cnt == 16'hffff)
    else $error("Bit error count wrapped");
  a_m_zero_idle: assert property (q.mmode == MM_ZERO && frame_i |=> m_sym_o == M_ZERO)
    else $error("Nonzero M symbol without loop request");
  a_m_alt_pair: assert property (q.mmode == MM_ALT && frame_i && !q.alt_ph && !ci_valid_i
    |=> m_sym_o == M_PLUS)
    else $error("Alternating request missed plus symbol");
  a_m_alt_len: assert property (q.mmode == MM_ALT |-> q.alt_cnt < 4'h8)
    else $error("Alternating request too long");
  a_m_plus_req: assert property (q.mmode == MM_PLUS && frame_i |=> m_sym_o == M_PLUS)
    else $error("Terminal loop request not sent");
  a_dlb_transp: assert property (q.loop[LOOP_DLB] && bit_valid_i
    |=> line_bit_o == $past(sys_bit_i) && sys_bit_o == $past(sys_bit_i))
    else $error("Framer loop not transparent");
  a_analog_path: assert property (q.analog && !q.loop[LOOP_DLB] && bit_valid_i
    |=> sys_bit_o == $past(sys_bit_i) && line_bit_o == $past(sys_bit_i))
    else $error("Analog loop path wrong");
  a_nontrans_idle: assert property (!q.analog && !q.loop[LOOP_DLB] && in_loop &&
    q.loop[LOOP_DIR] && !q.loop[LOOP_LOOP_TRANSPARENCY_BIT] |=> sys_bit_o)
    else $error("Non-transparent loop forwarded data");
endmodule

// *** testbench/llem_term_model.sv ***
`timescale 1ns/10ps
// Remote terminal: closes or opens its loop on M symbols, reports violations
module llem_term_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Line events seen by the terminal
  input wire logic frame_i,
  input wire logic cv_i,
  input wire logic [1:0] m_sym_i,
  // Terminal answers
  output logic m_plus_o,
  output logic loop_o
);
  import llem_pkg::*;
  logic [3:0] pc_q;
  logic [3:0] zc_q;
  logic err_q;
  assign m_plus_o = frame_i & err_q;
  // Run lengths of like symbols, violation memory
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_q <= 4'h0;
      zc_q <= 4'h0;
      err_q <= 1'h0;
      loop_o <= 1'h0;
    end else begin
      if (cv_i) begin
        err_q <= 1'h1;
      end else if (frame_i) begin
        err_q <= 1'h0;
      end
      if (frame_i && m_sym_i == M_PLUS) begin
        pc_q <= (pc_q == 4'h8) ? pc_q : pc_q + 4'h1;
        zc_q <= 4'h0;
        if (pc_q == 4'h7) begin
          loop_o <= 1'h1;
        end
      end else if (frame_i) begin
        zc_q <= (zc_q == 4'h8) ? zc_q : zc_q + 4'h1;
        pc_q <= 4'h0;
        if (zc_q == 4'h7) begin
          loop_o <= 1'h0;
        end
      end
    end
  end
endmodule

// *** testbench/line_loopback_error_monitor_tb.sv ***
`timescale 1ns/10ps
module line_loopback_error_monitor_tb;
  import llem_pkg::*;
  logic clk_sys_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ci_valid_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, ci_code_i, lt_state_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic frame_i, cv_i, m_rx_plus_i, mon_rds_req_i, mon_rds_valid_o, bit_valid_i;
  logic [7:0] mon_rds_data_o;
  logic [1:0] bit_chan_i, m_sym_o;
  logic sys_bit_i, line_bit_i, bit_valid_o, sys_bit_o, line_bit_o;
  logic analog_loop_o, act_inhibit_o, term_loop;
  int bad_count, compares;
  logic [3:0] st_tab [4] = '{ST_SYNC_NO_TE, ST_LINK_SYNC, ST_WAIT_1MS, ST_TRANSP};
  llem_monitor llem_monitor_inst (.clk_sys_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ci_valid_i, .ci_code_i,
    .lt_state_i, .frame_i, .cv_i, .m_rx_plus_i, .mon_rds_req_i, .mon_rds_valid_o,
    .mon_rds_data_o, .bit_valid_i, .bit_chan_i, .sys_bit_i, .line_bit_i, .bit_valid_o,
    .sys_bit_o, .line_bit_o, .analog_loop_o, .m_sym_o, .act_inhibit_o);
  llem_term_model llem_term_model_inst (.clk_sys_i, .rst_n_i, .frame_i, .cv_i,
    .m_sym_i(m_sym_o), .m_plus_o(m_rx_plus_i), .loop_o(term_loop));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic single Wishbone cycle, waits for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'h0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic cmd(input logic [3:0] c);
    @(posedge clk_sys_i);
    ci_valid_i <= 1'h1;
    ci_code_i <= c;
    @(posedge clk_sys_i);
    ci_valid_i <= 1'h0;
    @(negedge clk_sys_i);
  endtask
  // Frames of four cycles, violation in the second cycle
  task automatic frames(input int n, input logic v);
    repeat (n) begin
      @(posedge clk_sys_i);
      frame_i <= 1'h1;
      @(posedge clk_sys_i);
      frame_i <= 1'h0;
      cv_i <= v;
      @(posedge clk_sys_i);
      cv_i <= 1'h0;
      @(posedge clk_sys_i);
    end
    @(negedge clk_sys_i);
  endtask
  // One bit through the path, outputs judged a cycle later
  task automatic bitp(input logic [1:0] c, input logic s, l, es, el);
    @(posedge clk_sys_i);
    bit_valid_i <= 1'h1;
    bit_chan_i <= c;
    sys_bit_i <= s;
    line_bit_i <= l;
    @(posedge clk_sys_i);
    bit_valid_i <= 1'h0;
    sys_bit_i <= ~s;
    line_bit_i <= ~l;
    @(negedge clk_sys_i);
    chk("bit_valid", bit_valid_o, 1'h1);
    chk("sys_bit", sys_bit_o, es);
    chk("line_bit", line_bit_o, el);
  endtask
  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rdc(REG_LOOP, 32'h0, "loop");
    rdc(REG_TEST, 32'h0, "test");
    rdc(REG_LPSEL, 32'h0, "lpsel");
    wb(1'h1, 8'h40, 32'hff);
    rdc(8'h40, 32'h0, "unmapped");
    chk("m_sym", m_sym_o, M_ZERO);
    $display("reset test done");
  endtask
  task automatic t_mchan();
    frames(2, 1'h0);
    chk("m_sym idle", m_sym_o, M_ZERO);
    cmd(CI_AR4);
    for (int i = 0; i < 10; i++) begin
      frames(1, 1'h0);
      chk("m_sym alt", m_sym_o, (i < 8 && i % 2 == 0) ? M_PLUS : M_ZERO);
    end
    for (int k = 0; k < 2; k++) begin
      cmd(CI_AR2);
      frames(9, 1'h0);
      chk("m_sym plus", m_sym_o, M_PLUS);
      chk("term loop", term_loop, 1'h1);
      cmd(k ? CI_DR : CI_AR);
      frames(9, 1'h0);
      chk("m_sym zero", m_sym_o, M_ZERO);
      chk("term open", term_loop, 1'h0);
    end
    $display("m channel test done");
  endtask
  task automatic t_blk();
    for (int i = 0; i < 4; i++) begin
      lt_state_i <= st_tab[i];
      frames(1, 1'h1);
      frames(2, 1'h0);
      rdc(REG_BLKERR, 32'h2, "blk active");
    end
    lt_state_i <= ST_DEACT;
    frames(1, 1'h1);
    frames(2, 1'h0);
    rdc(REG_BLKERR, 32'h0, "blk held");
    lt_state_i <= ST_TRANSP;
    frames(130, 1'h1);
    frames(2, 1'h0);
    rdc(REG_BLKERR, 32'hff, "blk sat");
    rdc(REG_BLKERR, 32'h0, "blk clr");
    frames(3, 1'h1);
    frames(2, 1'h0);
    @(posedge clk_sys_i);
    mon_rds_req_i <= 1'h1;
    @(posedge clk_sys_i);
    mon_rds_req_i <= 1'h0;
    @(negedge clk_sys_i);
    chk("mon valid", mon_rds_valid_o, 1'h1);
    chk("mon data", mon_rds_data_o, 8'h6);
    rdc(REG_BLKERR, 32'h0, "blk mon clr");
    $display("block error test done");
  endtask
  task automatic t_ber();
    wb(1'h1, REG_LPSEL, 32'h0);
    wb(1'h1, REG_TEST, 32'h1);
    for (int i = 0; i < 10; i++) bitp(i % 3, 1'h0, 1'h1, 1'h1, 1'h0);
    rdc(REG_BER_HI, 32'h0, "ber hi");
    rdc(REG_BER_LO, 32'h4, "ber b1");
    rdc(REG_BER_LO, 32'h0, "ber clr");
    wb(1'h1, REG_TEST, 32'h7);
    for (int i = 0; i < 10; i++) bitp(i % 3, 1'h0, 1'h1, 1'h1, 1'h0);
    wb(1'h1, REG_TEST, 32'h0);
    for (int i = 0; i < 3; i++) bitp(i % 3, 1'h0, 1'h1, 1'h1, 1'h0);
    rdc(REG_BER_HI, 32'h0, "ber hi2");
    rdc(REG_BER_LO, 32'ha, "ber stop");
    $display("bit error test done");
  endtask
  task automatic t_loop();
    wb(1'h1, REG_LOOP, 32'h01);
    bitp(CH_B1, 1'h0, 1'h1, 1'h0, 1'h1);
    bitp(CH_B2, 1'h0, 1'h1, 1'h1, 1'h0);
    wb(1'h1, REG_LOOP, 32'h11);
    bitp(CH_B1, 1'h0, 1'h1, 1'h0, 1'h0);
    wb(1'h1, REG_LOOP, 32'h0a);
    bitp(CH_B2, 1'h1, 1'h0, 1'h1, 1'h0);
    wb(1'h1, REG_LOOP, 32'h04);
    bitp(CH_D, 1'h0, 1'h1, 1'h0, 1'h1);
    lt_state_i <= ST_DEACT;
    wb(1'h1, REG_LOOP, 32'h20);
    chk("inhibit", act_inhibit_o, 1'h1);
    bitp(CH_B1, 1'h0, 1'h1, 1'h0, 1'h0);
    wb(1'h1, REG_LOOP, 32'h0);
    chk("inhibit off", act_inhibit_o, 1'h0);
    $display("local loop test done");
  endtask
  task automatic t_analog();
    lt_state_i <= ST_TRANSP;
    cmd(CI_AR1);
    chk("analog", analog_loop_o, 1'h1);
    rdc(REG_STAT, 32'h1, "stat analog");
    bitp(CH_B1, 1'h0, 1'h1, 1'h0, 1'h0);
    bitp(CH_D, 1'h1, 1'h0, 1'h1, 1'h1);
    $display("analog loop test done");
  endtask
  // Clock, 20 ns period
  initial begin
    clk_sys_i = 1'h0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    close_out();
  end
  // Main sequence
  initial begin
    {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, ci_valid_i, frame_i, cv_i} = 7'h0;
    {mon_rds_req_i, bit_valid_i, sys_bit_i, line_bit_i} = 4'h0;
    {wb_adr_i, ci_code_i, bit_chan_i, wb_dat_i} = 46'h0;
    wb_sel_i = 4'hf;
    lt_state_i = ST_TRANSP;
    bad_count = 0;
    compares = 0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    t_reset();
    t_mchan();
    t_blk();
    t_ber();
    t_loop();
    t_analog();
    close_out();
  end
endmodule
